// ### rtl/drive_status_pkg.sv
// drive status bank: shared offsets, field positions, resets and types
// assumes a single 20 MHz clock domain and an AXI4-Lite register bus
package drive_status_pkg;
    // ----------------------------------------
    // bus and register map
    // ----------------------------------------
    localparam int unsigned ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_SPEED_PCT = 5'h00; // speed_percent_readback
    localparam logic [ADDR_W-1:0] OFS_FUNC_STAT = 5'h04; // drive_function_status
    localparam logic [ADDR_W-1:0] OFS_AUX_STAT = 5'h08; // auxiliary_storage_status
    localparam logic [ADDR_W-1:0] OFS_MAX_SPEED = 5'h0C; // maximum_speed_setting, rpm
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h10; // sticky events, read only
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 5'h14; // event enables
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 5'h18; // write one to clear
    localparam logic [ADDR_W-1:0] OFS_NOTICE = 5'h1C; // storage notice, write one to ack
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int FS_SELF_TUNE = 0;
    localparam int FS_PRECHARGE = 2;
    localparam int FS_DECEL = 5;
    localparam int FS_ACCEL = 6;
    localparam int FS_FROZEN = 7;
    localparam int FS_SETPOINT = 8;
    localparam int FS_DC_LIMIT = 9;
    localparam int FS_CUR_LIMIT = 10;
    localparam int FS_TRQ_LIMIT = 11;
    localparam int FS_RIDE = 12;
    localparam int FS_FLYING = 13;
    localparam int FS_DC_BRAKE = 14;
    localparam int FS_PWM = 15;
    localparam int AUX_CARD = 0;
    localparam int AUX_FULL = 2;
    localparam int IRQ_W = 4;
    localparam int IRQ_SETPOINT = 0; // setpoint reached, rising
    localparam int IRQ_FULL = 1; // storage became full, rising
    localparam int IRQ_LIMIT = 2; // any limitation began
    localparam int IRQ_PWM_OFF = 3; // output pulses stopped
    // ----------------------------------------
    // reset values and counts
    // ----------------------------------------
    localparam logic [15:0] MAX_SPEED_RST = 16'h0708;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;
    localparam int PCT_FULL_SCALE = 10000; // 100.00 % in hundredths
    localparam int PCT_LIMIT = 20000; // 200.00 % readback ceiling
    localparam int INIT_CYCLES = 4; // covers the card synchroniser depth
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_RUN = 2'b01
    } init_state_t;
    typedef struct packed {
        logic self_tuning;
        logic precharge_done;
        logic decelerating;
        logic accelerating;
        logic ramp_frozen;
        logic setpoint_ok;
        logic dc_or_cur_limit;
        logic cur_limit;
        logic torque_limit;
        logic ride_through;
        logic flying_start;
        logic dc_braking;
        logic pwm_enabled;
    } drive_func_t;
endpackage

// ### rtl/reg_req_if.sv
// register request carrier between the bus slave and the status bank
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface reg_req_if;
    import drive_status_pkg::*;
    logic wr_req; // one-cycle write strobe
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok; // address is mapped
    logic rd_req; // one-cycle read strobe
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    modport bus (output wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
        input wr_ok, rd_data, rd_ok);
    modport regs (input wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
        output wr_ok, rd_data, rd_ok);
endinterface // reg_req_if

// ### rtl/axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes
// assumes the master keeps valid and payload until the handshake
`timescale 1ns/100ps
module axil_slave (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic [drive_status_pkg::ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // read channels
    input wire logic [drive_status_pkg::ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // register side
    reg_req_if.bus rq
);
    import drive_status_pkg::*;
    logic wa_q, wa_d; // address and data taken this cycle
    logic bv_q, bv_d;
    logic [1:0] br_q, br_d;
    logic ra_q, ra_d;
    logic rv_q, rv_d;
    logic [1:0] rr_q, rr_d;
    logic [31:0] rd_q, rd_d;
    // ----------------------------------------
    // handshake next state
    // ----------------------------------------
    // waits for both write channels so one ready pulse takes address and data together
    always_comb begin
        wa_d = s_awvalid && s_wvalid && !wa_q && !bv_q;
        bv_d = bv_q;
        br_d = br_q;
        if (wa_q) begin
            bv_d = 1'b1;
            br_d = rq.wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bv_q && s_bready) begin
            bv_d = 1'b0;
        end
        ra_d = s_arvalid && !ra_q && !rv_q;
        rv_d = rv_q;
        rr_d = rr_q;
        rd_d = rd_q;
        if (ra_q) begin
            rv_d = 1'b1;
            rr_d = rq.rd_ok ? RESP_OKAY : RESP_SLVERR;
            rd_d = rq.rd_data;
        end else if (rv_q && s_rready) begin
            rv_d = 1'b0;
        end
    end
    // ----------------------------------------
    // handshake registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wa_q <= 1'b0;
            bv_q <= 1'b0;
            br_q <= RESP_OKAY;
            ra_q <= 1'b0;
            rv_q <= 1'b0;
            rr_q <= RESP_OKAY;
            rd_q <= 32'h0000_0000;
        end else begin
            wa_q <= wa_d;
            bv_q <= bv_d;
            br_q <= br_d;
            ra_q <= ra_d;
            rv_q <= rv_d;
            rr_q <= rr_d;
            rd_q <= rd_d;
        end
    end
    assign rq.wr_req = wa_q;
    assign rq.wr_addr = s_awaddr;
    assign rq.wr_data = s_wdata;
    assign rq.wr_strb = s_wstrb;
    assign rq.rd_req = ra_q;
    assign rq.rd_addr = s_araddr;
    assign s_awready = wa_q;
    assign s_wready = wa_q;
    assign s_bvalid = bv_q;
    assign s_bresp = br_q;
    assign s_arready = ra_q;
    assign s_rvalid = rv_q;
    assign s_rresp = rr_q;
    assign s_rdata = rd_q;
endmodule // axil_slave

// ### rtl/speed_scale.sv
// iterative scaler: signed rpm to signed hundredths of a percent of max speed
// assumes inputs from the same clock; result refreshes every PROD_W+1 cycles
`timescale 1ns/100ps
module speed_scale #(
    parameter int PROD_W = 29
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // operands
    input wire logic signed [15:0] speed_rpm,
    input wire logic [15:0] max_rpm,
    // result
    output logic signed [15:0] pct_q
);
    import drive_status_pkg::*;
    if (PROD_W < 29 || PROD_W > 31) $error("speed_scale: PROD_W out of range");
    logic [PROD_W-1:0] num_q, num_d; // shifting dividend
    logic [16:0] rem_q, rem_d;
    logic [PROD_W-1:0] quo_q, quo_d;
    logic [4:0] cnt_q, cnt_d;
    logic neg_q, neg_d;
    logic signed [15:0] pct_d;
    logic [16:0] trial;
    logic [PROD_W-1:0] mag;
    // ----------------------------------------
    // long division, one quotient bit a cycle
    // ----------------------------------------
    always_comb begin
        mag = PROD_W'(unsigned'(speed_rpm[15] ? 16'(-speed_rpm) : speed_rpm))
            * PROD_W'(PCT_FULL_SCALE);
        trial = {rem_q[15:0], num_q[PROD_W-1]};
        num_d = num_q << 1;
        rem_d = trial;
        quo_d = quo_q << 1;
        cnt_d = cnt_q - 5'd1;
        neg_d = neg_q;
        pct_d = pct_q;
        if (trial >= {1'b0, max_rpm}) begin
            rem_d = trial - {1'b0, max_rpm};
            quo_d[0] = 1'b1;
        end
        if (cnt_q == 5'd0) begin
            // publish and reload; zero max speed reads as standstill
            if (max_rpm == 16'h0000) begin
                pct_d = 16'sh0000;
            end else if (quo_q > PROD_W'(PCT_LIMIT)) begin
                pct_d = neg_q ? -16'(PCT_LIMIT) : 16'(PCT_LIMIT); // saturate at 200 %
            end else begin
                pct_d = neg_q ? -quo_q[15:0] : quo_q[15:0]; // reverse reads negative
            end
            num_d = mag;
            rem_d = 17'h00000;
            quo_d = '0;
            cnt_d = 5'(PROD_W);
            neg_d = speed_rpm[15];
        end
    end
    // ----------------------------------------
    // divider registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            num_q <= '0;
            rem_q <= 17'h00000;
            quo_q <= '0;
            cnt_q <= 5'h00;
            neg_q <= 1'b0;
            pct_q <= 16'sh0000;
        end else begin
            num_q <= num_d;
            rem_q <= rem_d;
            quo_q <= quo_d;
            cnt_q <= cnt_d;
            neg_q <= neg_d;
            pct_q <= pct_d; // 0 is standstill, 10000 is max speed
        end
    end
endmodule // speed_scale

// ### rtl/drive_status_bank.sv
// drive status bank: speed readback, function and storage status words,
// event interrupt, reached by software over AXI4-Lite
// assumes drive function flags arrive on aclk; the card pin is asynchronous
//
// Functional notes
// - speed reported as percent of maximum
// - reverse rotation gives negative speed
// - bit0 follows self-tuning running
// - bit2 set once precharge completed
// - bit5 decelerating, bit6 accelerating
// - bit7 shows ramp held frozen
// - bit8 set when speed reaches reference
// - bits 9-11 show limitation states independently
// - bits 12-14 ride-through, flying start, braking
// - bit15 follows output pulses enabled
// - card presence sampled only at initialization
// - aux bit2 set when storage full
// - full at power-on: notice, reclaim storage
// - full storage never stops drive operation
`timescale 1ns/100ps
module drive_status_bank (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [drive_status_pkg::ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read channels
    input wire logic [drive_status_pkg::ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // drive function inputs
    input wire drive_status_pkg::drive_func_t drive_func,
    input wire logic signed [15:0] speed_rpm,
    input wire logic card_present_pin,
    input wire logic storage_full,
    // outputs to the system
    output logic irq,
    output logic storage_notice,
    output logic storage_reclaim
);
    import drive_status_pkg::*;
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg_req_if rq (); // strobes from the bus slave
    init_state_t state_q, state_d; // initialization phase
    logic [2:0] init_cnt_q, init_cnt_d;
    logic card_meta_q; // first synchroniser stage only
    logic card_sync_q;
    logic card_q, card_d; // card presence latched at init
    logic [15:0] max_speed_q, max_speed_d; // software-set maximum speed
    logic [IRQ_W-1:0] irq_en_q, irq_en_d;
    logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
    logic [IRQ_W-1:0] event_now; // event strobes this cycle
    logic setpoint_prev_q, full_prev_q, limit_prev_q, pwm_prev_q;
    logic limit_any;
    logic irq_q, irq_d;
    logic notice_q, notice_d; // shown until software acknowledges
    logic reclaim_q, reclaim_d; // ask storage manager to free space
    logic [15:0] func_word; // drive_function_status image
    logic [2:0] aux_word; // auxiliary_storage_status image
    logic signed [15:0] pct; // latest speed percent
    logic [31:0] rd_data;
    logic rd_ok, wr_ok;
    logic [IRQ_W-1:0] clr_mask;

    // ----------------------------------------
    // submodules
    // ----------------------------------------
    // bus slave holds all AXI outputs in its own flip-flops
    axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .rq(rq.bus)
    );

    // speed scaler, refreshed continuously from the rpm input
    speed_scale #(
        .PROD_W(29)
    ) u_scale (
        .aclk(aclk),
        .aresetn(aresetn),
        .speed_rpm(speed_rpm),
        .max_rpm(max_speed_q),
        .pct_q(pct)
    );

    // ----------------------------------------
    // status word images
    // ----------------------------------------
    // flags come from drive logic on aclk, so no synchroniser is needed
    always_comb begin
        func_word = 16'h0000; // unused positions stay zero
        func_word[FS_SELF_TUNE] = drive_func.self_tuning;
        func_word[FS_PRECHARGE] = drive_func.precharge_done;
        func_word[FS_DECEL] = drive_func.decelerating;
        func_word[FS_ACCEL] = drive_func.accelerating;
        func_word[FS_FROZEN] = drive_func.ramp_frozen;
        func_word[FS_SETPOINT] = drive_func.setpoint_ok;
        func_word[FS_DC_LIMIT] = drive_func.dc_or_cur_limit;
        func_word[FS_CUR_LIMIT] = drive_func.cur_limit;
        func_word[FS_TRQ_LIMIT] = drive_func.torque_limit;
        func_word[FS_RIDE] = drive_func.ride_through;
        func_word[FS_FLYING] = drive_func.flying_start;
        func_word[FS_DC_BRAKE] = drive_func.dc_braking;
        func_word[FS_PWM] = drive_func.pwm_enabled;
        aux_word = 3'h0;
        aux_word[AUX_CARD] = card_q;
        aux_word[AUX_FULL] = storage_full;
    end

    // ----------------------------------------
    // register read decode
    // ----------------------------------------
    // unmapped addresses read zero and answer with a slave error
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        case (rq.rd_addr)
            OFS_SPEED_PCT: rd_data = {16'h0000, pct};
            OFS_FUNC_STAT: rd_data = {16'h0000, func_word};
            OFS_AUX_STAT: rd_data = {29'h0000_0000, aux_word};
            OFS_MAX_SPEED: rd_data = {16'h0000, max_speed_q};
            OFS_IRQ_STAT: rd_data = {28'h000_0000, irq_stat_q};
            OFS_IRQ_EN: rd_data = {28'h000_0000, irq_en_q};
            OFS_IRQ_CLR: rd_data = 32'h0000_0000; // write-only, reads zero
            OFS_NOTICE: rd_data = {31'h0000_0000, notice_q};
            default: rd_ok = 1'b0;
        endcase
    end
    assign rq.rd_data = rd_data;
    assign rq.rd_ok = rd_ok;

    // ----------------------------------------
    // register write decode
    // ----------------------------------------
    // writes to status words are accepted on the bus and change nothing
    always_comb begin
        case (rq.wr_addr)
            OFS_SPEED_PCT, OFS_FUNC_STAT, OFS_AUX_STAT: wr_ok = 1'b1;
            OFS_MAX_SPEED, OFS_IRQ_STAT, OFS_IRQ_EN: wr_ok = 1'b1;
            OFS_IRQ_CLR, OFS_NOTICE: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end
    assign rq.wr_ok = wr_ok;

    // ----------------------------------------
    // initialization sequence, next state
    // ----------------------------------------
    // the card level is caught once, after the synchroniser has settled;
    // a later removal is deliberately not seen
    always_comb begin
        state_d = state_q;
        init_cnt_d = init_cnt_q;
        card_d = card_q;
        notice_d = notice_q;
        reclaim_d = reclaim_q;
        case (state_q)
            ST_INIT: begin
                if (init_cnt_q == 3'(INIT_CYCLES - 1)) begin
                    state_d = ST_RUN;
                    card_d = card_sync_q; // single capture point
                    notice_d = storage_full; // show notice at power-on
                    reclaim_d = storage_full; // start freeing space
                end else begin
                    init_cnt_d = init_cnt_q + 3'd1;
                end
            end
            ST_RUN: begin
                // storage manager drops full once space is back
                if (!storage_full) begin
                    reclaim_d = 1'b0;
                end
                // acknowledge by writing one to bit 0
                if (rq.wr_req && rq.wr_addr == OFS_NOTICE && rq.wr_strb[0] && rq.wr_data[0]) begin
                    notice_d = 1'b0;
                end
            end
            default: begin
                state_d = ST_INIT;
                init_cnt_d = 3'h0;
            end
        endcase
    end

    // ----------------------------------------
    // initialization sequence, registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_INIT;
            init_cnt_q <= 3'h0;
            card_meta_q <= 1'b0;
            card_sync_q <= 1'b0;
            card_q <= 1'b0;
            notice_q <= 1'b0;
            reclaim_q <= 1'b0;
        end else begin
            state_q <= state_d;
            init_cnt_q <= init_cnt_d;
            card_meta_q <= card_present_pin; // two-stage synchroniser
            card_sync_q <= card_meta_q;
            card_q <= card_d;
            notice_q <= notice_d;
            reclaim_q <= reclaim_d;
        end
    end

    // ----------------------------------------
    // control registers and events, next state
    // ----------------------------------------
    // full storage only raises a flag, an event, the notice and reclaim; the drive flags and the
    // speed path never look at it
    always_comb begin
        limit_any = drive_func.dc_or_cur_limit | drive_func.cur_limit | drive_func.torque_limit;
        event_now = '0;
        event_now[IRQ_SETPOINT] = drive_func.setpoint_ok & ~setpoint_prev_q;
        event_now[IRQ_FULL] = storage_full & ~full_prev_q;
        event_now[IRQ_LIMIT] = limit_any & ~limit_prev_q;
        event_now[IRQ_PWM_OFF] = ~drive_func.pwm_enabled & pwm_prev_q;
        max_speed_d = max_speed_q;
        irq_en_d = irq_en_q;
        clr_mask = '0;
        if (rq.wr_req) begin
            case (rq.wr_addr)
                OFS_MAX_SPEED: begin
                    if (rq.wr_strb[0]) max_speed_d[7:0] = rq.wr_data[7:0];
                    if (rq.wr_strb[1]) max_speed_d[15:8] = rq.wr_data[15:8];
                end
                OFS_IRQ_EN: begin
                    if (rq.wr_strb[0]) irq_en_d = rq.wr_data[IRQ_W-1:0];
                end
                OFS_IRQ_CLR: begin
                    if (rq.wr_strb[0]) clr_mask = rq.wr_data[IRQ_W-1:0];
                end
                default: clr_mask = '0; // status words and others hold
            endcase
        end
        // a new event in the clearing cycle survives the clear
        irq_stat_d = (irq_stat_q & ~clr_mask) | event_now;
        irq_d = |(irq_stat_d & irq_en_d);
    end

    // ----------------------------------------
    // control registers and events, registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            max_speed_q <= MAX_SPEED_RST;
            irq_en_q <= IRQ_EN_RST;
            irq_stat_q <= '0;
            irq_q <= 1'b0;
            setpoint_prev_q <= 1'b0;
            full_prev_q <= 1'b0;
            limit_prev_q <= 1'b0;
            pwm_prev_q <= 1'b0;
        end else begin
            max_speed_q <= max_speed_d;
            irq_en_q <= irq_en_d;
            irq_stat_q <= irq_stat_d;
            irq_q <= irq_d;
            setpoint_prev_q <= drive_func.setpoint_ok;
            full_prev_q <= storage_full;
            limit_prev_q <= limit_any;
            pwm_prev_q <= drive_func.pwm_enabled;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign irq = irq_q;
    assign storage_notice = notice_q;
    assign storage_reclaim = reclaim_q;
endmodule // drive_status_bank

// ### bench/dsb_chk.sv
// checker: bus answer timing and storage outputs of the status bank
// assumes it is bound onto drive_status_bank
`timescale 1ns/100ps
module dsb_chk (
    // watched ports, grouped to save space
    input wire logic aclk, aresetn, s_awready, s_wready, s_bvalid, s_bready,
    input wire logic [1:0] s_bresp,
    input wire logic s_arready, s_rvalid, s_rready,
    input wire logic [31:0] s_rdata,
    input wire logic storage_full, storage_notice, storage_reclaim
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // answer comes one edge after the ready pulse
    sequence wr_go; s_awready ##1 s_bvalid; endsequence
    sequence rd_go; s_arready ##1 s_rvalid; endsequence
    a_aw_w_pair: assert property (s_awready == s_wready)
        else $error("write readies split");
    a_wr_answer: assert property (s_awready |-> wr_go)
        else $error("write answer late");
    a_rd_answer: assert property (s_arready |-> rd_go)
        else $error("read answer late");
    a_b_holds: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write answer dropped");
    a_r_holds: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read answer dropped");
    a_ar_pulse: assert property (s_arready |=> !s_arready)
        else $error("read ready stuck");
    a_reclaim_end: assert property (storage_reclaim && !storage_full |-> ##[1:2] !storage_reclaim)
        else $error("reclaim stuck");
    a_notice_pair: assert property ($rose(storage_notice) |-> storage_reclaim)
        else $error("notice without reclaim");
endmodule // dsb_chk
bind drive_status_bank dsb_chk chk_u (.aclk, .aresetn, .s_awready, .s_wready, .s_bvalid,
    .s_bready, .s_bresp, .s_arready, .s_rvalid, .s_rready, .s_rdata, .storage_full,
    .storage_notice, .storage_reclaim);

// ### bench/tb_drive_status_bank.sv
// testbench: drives the status bank over AXI4-Lite and its flag inputs
// assumes the checker is bound in by its own file
`timescale 1ns/100ps
module tb_drive_status_bank;
    import drive_status_pkg::*;
    logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0;
    logic s_arvalid = 0, s_rready = 0, card_present_pin = 1, storage_full = 0;
    logic [ADDR_W-1:0] s_awaddr = '0, s_araddr = '0;
    logic [31:0] s_wdata = '0, s_rdata;
    logic [3:0] s_wstrb = 4'hF;
    logic [1:0] s_bresp, s_rresp;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic irq, storage_notice, storage_reclaim;
    drive_func_t drive_func = '0;
    logic signed [15:0] speed_rpm = '0;
    int miscompares = 0, cmp_count = 0;
    int pos [13] = '{0, 2, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15}; // flag bit places
    drive_status_bank dut_u (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .drive_func, .speed_rpm,
        .card_present_pin, .storage_full, .irq, .storage_notice, .storage_reclaim);
    always #25 aclk = ~aclk;
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // outputs are looked at on the falling edge, where they have settled
    task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1;
        s_wvalid <= 1;
        s_bready <= 1;
        do @(negedge aclk); while (!s_awready);
        @(posedge aclk);
        s_awvalid <= 0;
        s_wvalid <= 0;
        do @(negedge aclk); while (!s_bvalid);
        chk("bresp", RESP_OKAY, s_bresp);
        @(posedge aclk);
        s_bready <= 0;
    endtask
    task automatic rc(string n, logic [ADDR_W-1:0] a, logic [31:0] e);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1;
        s_rready <= 1;
        do @(negedge aclk); while (!s_arready);
        @(posedge aclk);
        s_arvalid <= 0;
        do @(negedge aclk); while (!s_rvalid);
        chk(n, e, s_rdata);
        chk("rresp", RESP_OKAY, s_rresp);
        @(posedge aclk);
        s_rready <= 0;
    endtask
    task automatic tally_and_finish;
        $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_func; // one flag at a time lands on its own bit only
        for (int i = 0; i < 13; i++) begin
            drive_func <= 13'h1000 >> i;
            rc("func", OFS_FUNC_STAT, 32'h1 << pos[i]);
        end
        drive_func <= '0;
        wr(OFS_FUNC_STAT, 32'hFFFF);
        rc("func", OFS_FUNC_STAT, 32'h0);
    endtask
    task automatic t_speed; // 900 of 1800 rpm, then -450 of 3600 rpm
        speed_rpm <= 16'sd900;
        repeat (70) @(posedge aclk);
        rc("spd", OFS_SPEED_PCT, 32'h1388);
        wr(OFS_MAX_SPEED, 32'h0E10);
        speed_rpm <= -16'sd450;
        repeat (70) @(posedge aclk);
        rc("spd", OFS_SPEED_PCT, 32'hFB1E);
    endtask
    task automatic t_irq; // raise, clear, then mask the storage event
        wr(OFS_IRQ_CLR, 32'hF);
        wr(OFS_IRQ_EN, 32'h2);
        storage_full <= 1;
        repeat (3) @(posedge aclk);
        rc("aux", OFS_AUX_STAT, 32'h5);
        chk("irq", 1, irq);
        rc("spd", OFS_SPEED_PCT, 32'hFB1E);
        wr(OFS_IRQ_CLR, 32'h2);
        @(negedge aclk) chk("irq", 0, irq);
        wr(OFS_IRQ_EN, 32'h0);
        storage_full <= 0;
        @(posedge aclk) storage_full <= 1;
        repeat (3) @(posedge aclk);
        rc("istat", OFS_IRQ_STAT, 32'h2);
        chk("irq", 0, irq);
    endtask
    task automatic t_notice; // restart while full: notice and reclaim
        aresetn <= 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        repeat (8) @(posedge aclk);
        @(negedge aclk) chk("notice", 1, storage_notice);
        chk("reclaim", 1, storage_reclaim);
        @(posedge aclk) storage_full <= 0;
        repeat (3) @(negedge aclk);
        chk("reclaim", 0, storage_reclaim);
        wr(OFS_NOTICE, 32'h1);
        @(negedge aclk) chk("notice", 0, storage_notice);
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        repeat (10) @(posedge aclk);
        card_present_pin <= 0; // removal after init must not show
        rc("max", OFS_MAX_SPEED, 32'h0708);
        rc("en", OFS_IRQ_EN, 32'h0);
        rc("aux", OFS_AUX_STAT, 32'h1);
        t_func();
        t_speed();
        t_irq();
        t_notice();
        tally_and_finish();
    end
    initial begin // watchdog over about 20000 cycles
        #1000000;
        miscompares++;
        tally_and_finish();
    end
endmodule // tb_drive_status_bank
